// [core/sqc_top.sv]
// Sequencer rate and subsample configuration bank with its period and slot logic.
`timescale 1ns/1ps
`include "sqc_consts.svh"
module sqc_top #(
  parameter int CLK_NS = `SQC_CLK_PERIOD_NS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire sqc_pkg::sqc_reg_req_t  reg_req,
  output logic [7:0]                  reg_rdata,
  output logic [1:0]                  seq_start,
  output sqc_pkg::sqc_slot_t [1:0]    seq_slot
);

  localparam logic [15:0] UNIT_NS = 16'($rtoi(`SQC_BASE_UNIT_US * 1000.0));
  localparam logic [15:0] STEP_NS = 16'(CLK_NS);

  if (CLK_NS < 1 || CLK_NS >= int'(UNIT_NS)) begin : g_bad_clock
    $error("sqc_top clock period must be between 1 ns and the base unit.");
  end

  logic [7:0]                 cfg [`SQC_REG_COUNT];
  logic [7:0]                 next_cfg [`SQC_REG_COUNT];
  logic [7:0]                 next_rdata;
  logic [3:0]                 req_idx;
  logic [7:0]                 req_mask;
  logic [1:0]                 seq_enable;
  logic [15:0]                base_div;
  logic [1:0][15:0]           seq_div;
  logic [1:0][7:0]            adc1_mask;
  logic [1:0][7:0]            adc2_mask;
  logic [1:0][15:0]           mode_flat;
  logic [1:0]                 div_written;
  logic                       base_written;
  logic [15:0]                unit_acc;
  logic [15:0]                next_unit_acc;
  logic                       unit_tick;
  logic                       next_unit_tick;
  logic                       base_tick;
  logic [7:0]                 seq_config;

  function automatic logic [7:0] write_mask(input logic [7:0] a);
    case (a)
      `SQC_ADDR_SEQ_CONFIG:       write_mask = `SQC_MASK_SEQ_CONFIG;
      `SQC_ADDR_BASE_LOW,
      `SQC_ADDR_BASE_HIGH,
      `SQC_ADDR_SEQ1_DIV_LOW,
      `SQC_ADDR_SEQ1_DIV_HIGH,
      `SQC_ADDR_SEQ2_DIV_LOW,
      `SQC_ADDR_SEQ2_DIV_HIGH,
      `SQC_ADDR_ADC1_SEQA_MASK,
      `SQC_ADDR_ADC2_SEQA_MASK,
      `SQC_ADDR_SEQA_MODES_FIRST,
      `SQC_ADDR_SEQA_MODES_LAST,
      `SQC_ADDR_SEQB_MODES:       write_mask = `SQC_MASK_FULL;
      `SQC_ADDR_ADC1_SEQB_MASK,
      `SQC_ADDR_ADC2_SEQB_MASK:   write_mask = `SQC_MASK_NIBBLE;
      default:                    write_mask = `SQC_MASK_NONE;
    endcase
  endfunction

  function automatic logic [7:0] cfg_at(input logic [7:0] a);
    cfg_at = cfg[4'(a - `SQC_ADDR_FIRST)];
  endfunction

  assign req_idx  = 4'(reg_req.addr - `SQC_ADDR_FIRST);
  assign req_mask = write_mask(reg_req.addr);

  // Unmapped offsets have an empty mask, so writes vanish and reads give zero.
  always_comb begin
    next_cfg   = cfg;
    next_rdata = reg_rdata;
    if (reg_req.wr && req_mask != `SQC_MASK_NONE) begin
      next_cfg[req_idx] = reg_req.wdata & req_mask;
    end
    if (reg_req.rd) begin
      next_rdata = cfg[req_idx] & req_mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SQC_REG_COUNT; i++) begin
        cfg[i] <= `SQC_RESET_BYTE;
      end
      reg_rdata <= `SQC_RESET_BYTE;
    end else begin
      cfg       <= next_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // A process and not assigns: an assign would miss register changes seen only inside cfg_at.
  always_comb begin
    seq_config    = cfg_at(`SQC_ADDR_SEQ_CONFIG);
    seq_enable[0] = seq_config[`SQC_FIRST_EN_BIT];
    seq_enable[1] = seq_config[`SQC_SECOND_EN_BIT];
    base_div      = {cfg_at(`SQC_ADDR_BASE_HIGH), cfg_at(`SQC_ADDR_BASE_LOW)};
    seq_div[0]    = {cfg_at(`SQC_ADDR_SEQ1_DIV_HIGH), cfg_at(`SQC_ADDR_SEQ1_DIV_LOW)};
    seq_div[1]    = {cfg_at(`SQC_ADDR_SEQ2_DIV_HIGH), cfg_at(`SQC_ADDR_SEQ2_DIV_LOW)};
    adc1_mask[0]  = cfg_at(`SQC_ADDR_ADC1_SEQA_MASK);
    adc1_mask[1]  = cfg_at(`SQC_ADDR_ADC1_SEQB_MASK);
    adc2_mask[0]  = cfg_at(`SQC_ADDR_ADC2_SEQA_MASK);
    adc2_mask[1]  = cfg_at(`SQC_ADDR_ADC2_SEQB_MASK);
    mode_flat[0]  = {cfg_at(`SQC_ADDR_SEQA_MODES_FIRST),
                     cfg_at(`SQC_ADDR_SEQA_MODES_LAST)};
    mode_flat[1]  = {cfg_at(`SQC_ADDR_SEQB_MODES), `SQC_RESET_BYTE};
  end

  assign base_written   = reg_req.wr && (reg_req.addr == `SQC_ADDR_BASE_LOW ||
                                         reg_req.addr == `SQC_ADDR_BASE_HIGH);
  assign div_written[0] = reg_req.wr && (reg_req.addr == `SQC_ADDR_SEQ1_DIV_LOW ||
                                         reg_req.addr == `SQC_ADDR_SEQ1_DIV_HIGH);
  assign div_written[1] = reg_req.wr && (reg_req.addr == `SQC_ADDR_SEQ2_DIV_LOW ||
                                         reg_req.addr == `SQC_ADDR_SEQ2_DIV_HIGH);

  // The base unit is not a whole number of clock periods, so a remainder
  // accumulator keeps the long-run rate exact at the cost of one cycle jitter.
  always_comb begin
    next_unit_acc  = '0;
    next_unit_tick = 1'b0;
    if (|seq_enable) begin
      next_unit_acc = 16'(unit_acc + STEP_NS);
      if (next_unit_acc >= UNIT_NS) begin
        next_unit_acc  = 16'(next_unit_acc - UNIT_NS);
        next_unit_tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_acc  <= '0;
      unit_tick <= 1'b0;
    end else begin
      unit_acc  <= next_unit_acc;
      unit_tick <= next_unit_tick;
    end
  end

  sqc_divider #(.W(`SQC_DIV_WIDTH)) u_base_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (|seq_enable),
    .in_tick  (unit_tick),
    .div      (base_div),
    .out_tick (base_tick)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [16:0] unit_count;
  logic        unit_clean;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_count <= '0;
      unit_clean <= 1'b0;
    end else if (!(|seq_enable) || base_written) begin
      unit_count <= '0;
      unit_clean <= 1'b0;
    end else if (base_tick) begin
      unit_count <= '0;
      unit_clean <= 1'b1;
    end else if (unit_tick) begin
      unit_count <= 17'(unit_count + 1'b1);
    end
  end

  base_period_a: assert property (
    base_tick && unit_clean |-> unit_count == 17'({1'b0, base_div} + 17'h00001))
    else $error("Base period does not match the base value plus one.");

  unmapped_read_a: assert property (
    reg_req.rd && req_mask == `SQC_MASK_NONE |=> reg_rdata == `SQC_RESET_BYTE)
    else $error("Unmapped register read did not return zero.");

  high_byte_a: assert property (
    reg_req.wr && reg_req.addr == `SQC_ADDR_SEQ1_DIV_HIGH |=>
      seq_div[0][15:8] == $past(reg_req.wdata))
    else $error("First divider high byte not taken from its register.");

  low_byte_a: assert property (
    reg_req.wr && reg_req.addr == `SQC_ADDR_SEQ2_DIV_LOW |=>
      seq_div[1][7:0] == $past(reg_req.wdata) && $stable(seq_div[1][15:8]))
    else $error("Second divider low byte not taken from its register.");

  for (genvar s = 0; s < 2; s++) begin : g_seq
    localparam logic [2:0] LAST_SLOT = (s == 0) ? 3'(`SQC_SEQ1_SLOTS - 1)
                                                : 3'(`SQC_SEQ2_SLOTS - 1);

    sqc_pkg::sqc_walk_t state;
    sqc_pkg::sqc_walk_t next_state;
    logic [2:0]         slot;
    logic [2:0]         next_slot;
    sqc_pkg::sqc_slot_t next_out;
    logic [16:0]        period_count;
    logic               period_clean;

    sqc_divider #(.W(`SQC_DIV_WIDTH)) u_seq_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .enable   (seq_enable[s]),
      .in_tick  (base_tick),
      .div      (seq_div[s]),
      .out_tick (seq_start[s])
    );

    // One slot per clock after each sample start; a dropped enable aborts the walk.
    always_comb begin
      next_state = state;
      next_slot  = slot;
      next_out   = '0;
      case (state)
        sqc_pkg::SQC_WALK_IDLE: begin
          if (seq_start[s] && seq_enable[s]) begin
            next_state = sqc_pkg::SQC_WALK_RUN;
            next_slot  = '0;
          end
        end
        sqc_pkg::SQC_WALK_RUN: begin
          if (!seq_enable[s]) begin
            next_state = sqc_pkg::SQC_WALK_IDLE;
          end else begin
            next_out.valid     = 1'b1;
            next_out.slot      = slot;
            next_out.mode      = sqc_pkg::sqc_mode_t'(2'(mode_flat[s] >>
                                 (`SQC_MODE_TOP_SHIFT - {slot, 1'b0})));
            next_out.adc1_conv = adc1_mask[s][slot];
            next_out.adc2_conv = adc2_mask[s][slot];
            if (slot == LAST_SLOT) begin
              next_state = sqc_pkg::SQC_WALK_IDLE;
            end else begin
              next_slot = 3'(slot + 1'b1);
            end
          end
        end
        default: begin
          next_state = sqc_pkg::SQC_WALK_IDLE;
        end
      endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        state       <= sqc_pkg::SQC_WALK_IDLE;
        slot        <= '0;
        seq_slot[s] <= '0;
      end else begin
        state       <= next_state;
        slot        <= next_slot;
        seq_slot[s] <= next_out;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        period_count <= '0;
        period_clean <= 1'b0;
      end else if (!seq_enable[s] || div_written[s]) begin
        period_count <= '0;
        period_clean <= 1'b0;
      end else if (seq_start[s]) begin
        period_count <= '0;
        period_clean <= 1'b1;
      end else if (base_tick) begin
        period_count <= 17'(period_count + 1'b1);
      end
    end

    seq_period_a: assert property (
      seq_start[s] && period_clean |->
        period_count == 17'({1'b0, seq_div[s]} + 17'h00001))
      else $error("Sample period does not match the divider plus one.");

    idle_off_a: assert property (
      !seq_enable[s] |=> !seq_start[s] ##1 !seq_slot[s].valid)
      else $error("Sequencer produced activity while disabled.");

    slot_skip_a: assert property (
      seq_slot[s].valid |->
        seq_slot[s].adc1_conv == 1'($past(adc1_mask[s]) >> seq_slot[s].slot) &&
        seq_slot[s].adc2_conv == 1'($past(adc2_mask[s]) >> seq_slot[s].slot))
      else $error("Slot conversion does not follow the ADC slot mask.");

    mode_map_a: assert property (
      seq_slot[s].valid |-> seq_slot[s].mode ==
        sqc_pkg::sqc_mode_t'(2'($past(mode_flat[s]) >>
          (`SQC_MODE_TOP_SHIFT - {seq_slot[s].slot, 1'b0}))))
      else $error("Slot mode not taken from its bit pair.");

    walk_start_a: assert property (
      seq_start[s] && seq_enable[s] && state == sqc_pkg::SQC_WALK_IDLE
        ##1 seq_enable[s] |=> seq_slot[s].valid && seq_slot[s].slot == 3'h0)
      else $error("Slot walk did not begin with slot one.");

    slot_bound_a: assert property (
      seq_slot[s].valid |-> seq_slot[s].slot <= LAST_SLOT)
      else $error("Slot index beyond the sequencer slot count.");
  end

endmodule // sqc_top

// [core/sqc_consts.svh]
// Register offsets, field positions, reset values and timing figures of the sequencer config bank.
`ifndef SQC_CONSTS_SVH
`define SQC_CONSTS_SVH

`define SQC_ADDR_FIRST            8'h43
`define SQC_ADDR_SEQ_CONFIG       8'h43
`define SQC_ADDR_BASE_LOW         8'h46
`define SQC_ADDR_BASE_HIGH        8'h47
`define SQC_ADDR_SEQ1_DIV_LOW     8'h48
`define SQC_ADDR_SEQ1_DIV_HIGH    8'h49
`define SQC_ADDR_SEQ2_DIV_LOW     8'h4A
`define SQC_ADDR_SEQ2_DIV_HIGH    8'h4B
`define SQC_ADDR_ADC1_SEQA_MASK   8'h4C
`define SQC_ADDR_ADC1_SEQB_MASK   8'h4D
`define SQC_ADDR_ADC2_SEQA_MASK   8'h4E
`define SQC_ADDR_ADC2_SEQB_MASK   8'h4F
`define SQC_ADDR_SEQA_MODES_FIRST 8'h50
`define SQC_ADDR_SEQA_MODES_LAST  8'h51
`define SQC_ADDR_SEQB_MODES       8'h52

`define SQC_REG_COUNT             16
`define SQC_RESET_BYTE            8'h00
`define SQC_MASK_FULL             8'hFF
`define SQC_MASK_NIBBLE           8'h0F
`define SQC_MASK_SEQ_CONFIG       8'h88
`define SQC_MASK_NONE             8'h00
`define SQC_FIRST_EN_BIT          3
`define SQC_SECOND_EN_BIT         7

`define SQC_SEQ1_SLOTS            8
`define SQC_SEQ2_SLOTS            4
`define SQC_MODE_TOP_SHIFT        4'hE

`define SQC_CLK_PERIOD_NS         40
`define SQC_BASE_UNIT_US          31.25
`define SQC_DIV_WIDTH             16

`endif

// [core/sqc_pkg.sv]
// Types shared by the sequencer config bank and its test bench.
package sqc_pkg;

  typedef enum logic [1:0] {
    SQC_MODE_SINGLE     = 2'h0,
    SQC_MODE_DOUBLE     = 2'h1,
    SQC_MODE_TRIPLE     = 2'h2,
    SQC_MODE_SAR_SINGLE = 2'h3
  } sqc_mode_t;

  typedef enum logic {
    SQC_WALK_IDLE = 1'h0,
    SQC_WALK_RUN  = 1'h1
  } sqc_walk_t;

  typedef struct packed {
    logic      valid;
    logic [2:0] slot;
    sqc_mode_t mode;
    logic      adc1_conv;
    logic      adc2_conv;
  } sqc_slot_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sqc_reg_req_t;

endpackage

// [core/sqc_divider.sv]
// Tick divider: one output pulse for every div+1 input ticks.
`timescale 1ns/1ps
`include "sqc_consts.svh"
module sqc_divider #(
  parameter int W = `SQC_DIV_WIDTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         enable,
  input  wire logic         in_tick,
  input  wire logic [W-1:0] div,
  output logic              out_tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_out_tick;

  if (W < 1) begin : g_bad_width
    $error("sqc_divider needs a width of at least one bit.");
  end

  // A greater-or-equal compare lets a period shortened on the fly end at once.
  always_comb begin
    next_count    = count;
    next_out_tick = 1'b0;
    if (!enable) begin
      next_count = '0;
    end else if (in_tick) begin
      if (count >= div) begin
        next_count    = '0;
        next_out_tick = 1'b1;
      end else begin
        next_count = W'(count + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= '0;
      out_tick <= 1'b0;
    end else begin
      count    <= next_count;
      out_tick <= next_out_tick;
    end
  end

endmodule // sqc_divider

// [tb/sqc_host.sv]
// Host-side model that drives the bank's register strobe port.
`timescale 1ns/1ps
module sqc_host (
  input  wire logic             clk,
  input  wire logic [7:0]       reg_rdata,
  output sqc_pkg::sqc_reg_req_t reg_req
);
  initial reg_req = '0;

  // After each transfer the address and data lines show the inverse of the last values.
  // This keeps a design that samples them outside a strobe from passing by luck.
  task automatic release_bus;
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req.addr  = a;
    reg_req.wdata = d;
    reg_req.wr    = 1'b1;
    @(negedge clk);
    release_bus();
  endtask

  // Read data is captured half a cycle after the strobe is taken.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_req.addr = a;
    reg_req.rd   = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    release_bus();
  endtask
endmodule // sqc_host

// [tb/sequencer_rate_subsample_config_tb.sv]
// Self-checking bench for the sequencer rate and subsample configuration bank.
`timescale 1ns/1ps
`include "sqc_consts.svh"
module sequencer_rate_subsample_config_tb;
  logic                     clk;
  logic                     rst_n;
  sqc_pkg::sqc_reg_req_t    reg_req;
  logic [7:0]               reg_rdata;
  logic [1:0]               seq_start;
  sqc_pkg::sqc_slot_t [1:0] seq_slot;
  int                       failures;
  int                       checked;
  logic [7:0]               rd_val;
  // Setup table: base value 7 gives a base period of exactly 25 scaled clocks.
  logic [7:0] tab_a [14] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C,
                             8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h44};
  logic [7:0] tab_w [14] = '{8'h07, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01, 8'hA5,
                             8'hF9, 8'h3C, 8'hF6, 8'h1B, 8'hE4, 8'h6C, 8'hFF};
  logic [7:0] tab_e [14] = '{8'h07, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01, 8'hA5,
                             8'h09, 8'h3C, 8'h06, 8'h1B, 8'hE4, 8'h6C, 8'h00};

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // A 10 us design clock shrinks the 31.25 us unit to about three cycles.
  sqc_top #(.CLK_NS(10000)) sqc_top_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .seq_start (seq_start),
    .seq_slot  (seq_slot)
  );

  sqc_host sqc_host_inst (
    .clk       (clk),
    .reg_rdata (reg_rdata),
    .reg_req   (reg_req)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Waits for a start, checks every slot strobe of the walk, then times the next start.
  task automatic run_seq(input int s, input logic [15:0] period, input logic [15:0] modes,
                         input logic [7:0] m1, input logic [7:0] m2, input int slots);
    sqc_pkg::sqc_slot_t e;
    logic [15:0]        cnt;
    int                 i;
    int                 k;
    i = 0;
    while (seq_start[s] !== 1'b1 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    check("start", 16'(seq_start[s]), 16'h0001);
    cnt = 16'h0000;
    do begin
      @(negedge clk);
      cnt++;
      k = int'(cnt) - 2;
      e = '0;
      if (k >= 0 && k < slots) begin
        e.valid     = 1'b1;
        e.slot      = 3'(k);
        e.mode      = sqc_pkg::sqc_mode_t'(modes[15 - 2 * k -: 2]);
        e.adc1_conv = m1[k];
        e.adc2_conv = m2[k];
      end
      if (k >= 0 && k <= slots) check("slot", 16'(seq_slot[s]), 16'(e));
    end while (seq_start[s] !== 1'b1 && cnt < 16'h9000);
    check("period", cnt, period);
  endtask

  // Counts starts and slot strobes of one sequencer over a span; none may appear.
  task automatic quiet(input int s);
    logic [15:0] n;
    n = 16'h0000;
    repeat (7000) begin
      @(negedge clk);
      if (seq_start[s] !== 1'b0 || seq_slot[s].valid !== 1'b0) n++;
    end
    check("idle", n, 16'h0000);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    failures = 0;
    checked  = 0;
    rst_n    = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 16'h43; a <= 16'h52; a++) begin
      sqc_host_inst.read(8'(a), rd_val);
      check("reset", 16'(rd_val), 16'h0000);
    end
    for (int i = 0; i < 14; i++) begin
      sqc_host_inst.write(tab_a[i], tab_w[i]);
    end
    for (int i = 0; i < 14; i++) begin
      sqc_host_inst.read(tab_a[i], rd_val);
      check("readback", 16'(rd_val), 16'(tab_e[i]));
    end
    sqc_host_inst.write(`SQC_ADDR_SEQ_CONFIG, 8'hFF);
    sqc_host_inst.read(`SQC_ADDR_SEQ_CONFIG, rd_val);
    check("enables", 16'(rd_val), 16'h0088);
    run_seq(0, 16'd6475, 16'h1BE4, 8'hA5, 8'h3C, 8);
    run_seq(1, 16'd6425, 16'h6C00, 8'h09, 8'h06, 4);
    sqc_host_inst.write(`SQC_ADDR_SEQ_CONFIG, 8'h08);
    quiet(1);
    sqc_host_inst.write(`SQC_ADDR_SEQ_CONFIG, 8'h00);
    quiet(0);
    print_verdict();
  end
endmodule // sequencer_rate_subsample_config_tb
